// File: common/ddr3_cmd_defs.vh
/*
 * constants for the ddr3 command/address front end: command codes,
 * address fields, mode register fields and latency figures.
 * assumes it is included by bare name from the design file.
 */
// Notes on behaviour
// - inputs captured only where true clock rises (complement falls).
// - read data timed to both crossing directions of the clock pair; code takes the falling one from the true clock alone.
// - clock enable sampled low freezes internal clock, outputs and burst address.
// - power-down or self-refresh entry only when all banks idle.
// - three bank address bits select target bank of activate, read, write, precharge.
// - activate takes row address from all thirteen address bits.
// - read and write take column address from ten lowest address bits.
// - mode register set writes address bits as op-code into selected register.
// - eight independent banks each hold an open row concurrently.
// - additive latency programmable to zero, cas latency minus one or two.
// - burst length programmable to four or eight.
// - burst order selectable sequential or interleaved.
// - cas latency 14 clocks; activate-to-column and precharge 13.09 ns.
// - data transfers clocked by data strobe pair, not command clock.
// - one bit per pin per clock edge, double data rate.
// - chip select high masks every command; it is part of the code.
// - activate, precharge, read, write decoded from row, column, write strobes.
// - address bit ten: auto-precharge on access, all banks on precharge.
// - address bit twelve low chops burst on the fly, high full burst.
`ifndef DDR3_CMD_DEFS_VH
`define DDR3_CMD_DEFS_VH

// -----------------------------------------------------------------
// command codes {ras_n, cas_n, we_n}
// -----------------------------------------------------------------
`define CMD_MRS       3'h0
`define CMD_REF       3'h1
`define CMD_PRE       3'h2
`define CMD_ACT       3'h3
`define CMD_WR        3'h4
`define CMD_RD        3'h5
`define CMD_NOP       3'h7

// -----------------------------------------------------------------
// address fields
// -----------------------------------------------------------------
`define ADDR_AP_BIT   10
`define ADDR_BC_BIT   12
`define COL_W         10

// -----------------------------------------------------------------
// mode register fields
// -----------------------------------------------------------------
`define MR0_SEL       3'h0
`define MR1_SEL       3'h1
`define MR0_BL_LSB    0
`define MR0_BT_BIT    3
`define MR1_AL_LSB    3
`define BL_FIXED8     2'h0
`define BL_OTF        2'h1
`define BL_CHOP4      2'h2
`define AL_ZERO       2'h0
`define AL_CL_M1      2'h1
`define AL_CL_M2      2'h2

// -----------------------------------------------------------------
// latencies
// -----------------------------------------------------------------
`define CAS_LAT       14
`define T_RCD_PS      13090
`define T_RP_PS       13090
`define LINK_PERIOD_PS 938

`endif

// File: hdl/ddr3_cmd_front.v
/*
 * ddr3 command/address front end: samples the command pins on rising
 * edges of the link clock (seen through a synchroniser), decodes
 * commands, tracks eight banks, holds mode settings and produces a
 * read-data burst on both clock edges.
 * assumes the link clock is much slower than clk_i (80 ns vs 10 ns),
 * and all link pins are stable around the link rising edge.
 */
`timescale 1ns/10ps
`include "ddr3_cmd_defs.vh"

module ddr3_cmd_front #(
    parameter NBANK = 8,
    parameter ROW_W = 13,
    parameter BA_W  = 3,
    parameter DQ_W  = 16
) (
    input  wire              clk_i,
    input  wire              sys_rst_i,
    input  wire              ck_i,
    input  wire              ck_n_i,
    input  wire              cke_i,
    input  wire              cs_n_i,
    input  wire              ras_n_i,
    input  wire              cas_n_i,
    input  wire              we_n_i,
    input  wire [BA_W-1:0]   ba_i,
    input  wire [ROW_W-1:0]  addr_i,
    output reg  [NBANK-1:0]  bank_open_o,
    output reg               power_down_o,
    output reg  [ROW_W-1:0]  act_row_o,
    output reg  [`COL_W-1:0] col_o,
    output reg  [BA_W-1:0]   col_bank_o,
    output reg               col_valid_o,
    output reg               col_write_o,
    output reg               auto_pre_o,
    output reg  [3:0]        burst_len_o,
    output reg               burst_ilv_o,
    output reg  [1:0]        add_lat_o,
    output reg  [DQ_W-1:0]   dq_o,
    output reg               dq_oe_o,
    output reg               dqs_o,
    output reg               dqs_oe_o,
    output reg               mode_err_o
);

    // -----------------------------------------------------------------
    // synchronisers
    // -----------------------------------------------------------------
    reg [2:0] ck_s;
    reg [2:0] ckn_s;
    reg [1:0] cke_s, cs_s, ras_s, cas_s, we_s;
    reg [BA_W-1:0]  ba_s0, ba_s1;
    reg [ROW_W-1:0] ad_s0, ad_s1;

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ck_s  <= 3'h0;
            ckn_s <= 3'h7;
            cke_s <= 2'h0;
            cs_s  <= 2'h3;
            ras_s <= 2'h3;
            cas_s <= 2'h3;
            we_s  <= 2'h3;
            ba_s0 <= {BA_W{1'b0}};
            ba_s1 <= {BA_W{1'b0}};
            ad_s0 <= {ROW_W{1'b0}};
            ad_s1 <= {ROW_W{1'b0}};
        end else begin
            ck_s  <= {ck_s[1:0], ck_i};
            ckn_s <= {ckn_s[1:0], ck_n_i};
            cke_s <= {cke_s[0], cke_i};
            cs_s  <= {cs_s[0], cs_n_i};
            ras_s <= {ras_s[0], ras_n_i};
            cas_s <= {cas_s[0], cas_n_i};
            we_s  <= {we_s[0], we_n_i};
            ba_s0 <= ba_i;
            ba_s1 <= ba_s0;
            ad_s0 <= addr_i;
            ad_s1 <= ad_s0;
        end
    end

    wire ck_rise = ck_s[1] & ~ck_s[2] & ~ckn_s[1] & ckn_s[2];
    // falling edge of the true clock alone drives second data half
    wire ck_fall = ~ck_s[1] & ck_s[2];

    // -----------------------------------------------------------------
    // command decode
    // -----------------------------------------------------------------
    reg        cke_prev;
    wire [2:0] cmd = {ras_s[1], cas_s[1], we_s[1]};
    // internal clock runs only while cke held
    wire       run = ck_rise & cke_prev;
    wire       sel = run & ~cs_s[1];
    wire       all_idle = ~|bank_open_o;

    reg [2:0]  mr_bl_raw;
    reg [3:0]  beat;
    reg [3:0]  beats_left;
    reg [`COL_W-1:0] burst_col;
    reg        bursting;
    reg        rd_burst;
    reg [1:0]  next_al;

    always @* begin
        next_al = ad_s1[`MR1_AL_LSB+1:`MR1_AL_LSB];
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cke_prev     <= 1'b0;
            bank_open_o  <= {NBANK{1'b0}};
            power_down_o <= 1'b0;
            act_row_o    <= {ROW_W{1'b0}};
            col_o        <= {`COL_W{1'b0}};
            col_bank_o   <= {BA_W{1'b0}};
            col_valid_o  <= 1'b0;
            col_write_o  <= 1'b0;
            auto_pre_o   <= 1'b0;
            burst_len_o  <= 4'h8;
            burst_ilv_o  <= 1'b0;
            add_lat_o    <= `AL_ZERO;
            mode_err_o   <= 1'b0;
            mr_bl_raw    <= 3'h0;
        end else begin
            col_valid_o <= 1'b0;
            if (ck_rise) begin
                cke_prev <= cke_s[1];
                // power-down entry only with all banks idle
                if (cke_prev && !cke_s[1] && all_idle)
                    power_down_o <= 1'b1;
                else if (cke_s[1])
                    power_down_o <= 1'b0;
            end
            if (sel) begin
                // code from row, column, write strobes
                case (cmd)
                    `CMD_ACT: begin
                        bank_open_o[ba_s1] <= 1'b1;
                        act_row_o          <= ad_s1;
                    end
                    `CMD_PRE: begin
                        if (ad_s1[`ADDR_AP_BIT])
                            bank_open_o <= {NBANK{1'b0}};
                        else
                            bank_open_o[ba_s1] <= 1'b0;
                    end
                    `CMD_RD, `CMD_WR: begin
                        col_o       <= ad_s1[`COL_W-1:0];
                        col_bank_o  <= ba_s1;
                        col_valid_o <= 1'b1;
                        col_write_o <= ~we_s[1];
                        auto_pre_o  <= ad_s1[`ADDR_AP_BIT];
                        if (mr_bl_raw[1:0] == `BL_OTF)
                            burst_len_o <= ad_s1[`ADDR_BC_BIT] ? 4'h8 : 4'h4;
                        if (ad_s1[`ADDR_AP_BIT])
                            bank_open_o[ba_s1] <= 1'b0;
                    end
                    `CMD_MRS: begin
                        if (ba_s1 == `MR0_SEL) begin
                            mr_bl_raw <= {1'b0, ad_s1[1:0]};
                            burst_len_o <= (ad_s1[1:0] == `BL_CHOP4) ? 4'h4 : 4'h8;
                            burst_ilv_o <= ad_s1[`MR0_BT_BIT];
                            mode_err_o  <= (ad_s1[1:0] == 2'h3);
                        end else if (ba_s1 == `MR1_SEL) begin
                            if (next_al != 2'h3)
                                add_lat_o <= next_al;
                            mode_err_o <= (next_al == 2'h3);
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // read data path
    // -----------------------------------------------------------------
    // read latency counts cas latency plus additive latency in link clocks
    reg  [4:0] lat_cnt;
    wire [4:0] rd_lat = (add_lat_o == `AL_ZERO) ? 5'd`CAS_LAT :
                        5'd`CAS_LAT + 5'd`CAS_LAT - {3'h0, add_lat_o};
    wire [`COL_W-1:0] seq_col = burst_col + {6'h0, beat};
    wire [`COL_W-1:0] ilv_col = burst_col ^ {6'h0, beat};

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lat_cnt    <= 5'h00;
            rd_burst   <= 1'b0;
            bursting   <= 1'b0;
            beat       <= 4'h0;
            beats_left <= 4'h0;
            burst_col  <= {`COL_W{1'b0}};
            dq_o       <= {DQ_W{1'b0}};
            dq_oe_o    <= 1'b0;
            dqs_o      <= 1'b0;
            dqs_oe_o   <= 1'b0;
        end else begin
            if (sel && cmd == `CMD_RD) begin
                rd_burst  <= 1'b1;
                lat_cnt   <= rd_lat;
                burst_col <= ad_s1[`COL_W-1:0];
            end else if (run && rd_burst) begin
                if (lat_cnt == 5'h01) begin
                    rd_burst   <= 1'b0;
                    bursting   <= 1'b1;
                    beat       <= 4'h0;
                    beats_left <= burst_len_o;
                end
                lat_cnt <= lat_cnt - 5'h01;
            end
            if (bursting && (run || (ck_fall && cke_prev))) begin
                dq_o       <= {{(DQ_W-`COL_W){1'b0}},
                               burst_ilv_o ? ilv_col : seq_col};
                dq_oe_o    <= 1'b1;
                dqs_oe_o   <= 1'b1;
                dqs_o      <= ~dqs_o;
                beat       <= beat + 4'h1;
                beats_left <= beats_left - 4'h1;
                if (beats_left == 4'h1)
                    bursting <= 1'b0;
            end else if (!bursting) begin
                dq_oe_o  <= 1'b0;
                dqs_oe_o <= 1'b0;
                dqs_o    <= 1'b0;
            end
        end
    end

endmodule

// File: verification/ddr3_cmd_front_asserts.sv
/*
 * port assertions for ddr3_cmd_front.
 * assumes a bind onto that module; single clock domain clk_i.
 */
`timescale 1ns/10ps
module ddr3_cmd_front_asserts #(
    parameter NBANK = 8
) (
    input wire             clk_i,
    input wire             sys_rst_i,
    input wire             cke_i,
    input wire             cs_n_i,
    input wire [NBANK-1:0] bank_open_o,
    input wire             power_down_o,
    input wire [9:0]       col_o,
    input wire             col_valid_o,
    input wire             col_write_o,
    input wire [3:0]       burst_len_o,
    input wire [1:0]       add_lat_o,
    input wire             dq_oe_o,
    input wire             dqs_o,
    input wire             dqs_oe_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (sys_rst_i);
// ----------------------------------------
// helper: cycles since select seen low
// ----------------------------------------
reg [4:0] cs_idle;
always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) cs_idle <= 5'h1f;
    else if (!cs_n_i) cs_idle <= 5'h00;
    else if (cs_idle != 5'h1f) cs_idle <= cs_idle + 5'h01;
end
property p_col_pulse; col_valid_o |=> !col_valid_o; endproperty
a_col_pulse: assert property (p_col_pulse) else $error("column strobe held");
property p_col_hold; $changed(col_o) |-> col_valid_o; endproperty
a_col_hold: assert property (p_col_hold) else $error("column moved alone");
property p_bl_legal; burst_len_o == 4'h4 || burst_len_o == 4'h8; endproperty
a_bl_legal: assert property (p_bl_legal) else $error("bad burst length");
property p_al_legal; add_lat_o != 2'h3; endproperty
a_al_legal: assert property (p_al_legal) else $error("bad additive latency");
property p_pd_idle; power_down_o |-> bank_open_o == '0; endproperty
a_pd_idle: assert property (p_pd_idle) else $error("power down with open bank");
property p_pd_frozen;
    power_down_o && $past(power_down_o) |-> $stable(bank_open_o) && !col_valid_o;
endproperty
a_pd_frozen: assert property (p_pd_frozen) else $error("state moved in power down");
// chip select is part of every command code
property p_cs_gate; col_valid_o |-> cs_idle < 5'h14; endproperty
a_cs_gate: assert property (p_cs_gate) else $error("access while deselected");
property p_rd_burst; col_valid_o && !col_write_o |-> ##[1:600] dq_oe_o; endproperty
a_rd_burst: assert property (p_rd_burst) else $error("read burst missing");
property p_dqs_oe; dq_oe_o |-> dqs_oe_o; endproperty
a_dqs_oe: assert property (p_dqs_oe) else $error("data without strobe");
// a frozen clock stalls the strobe, so a low enable excuses it
property p_dqs_run; dqs_oe_o |-> ##[1:20] ($changed(dqs_o) || !dqs_oe_o || !cke_i); endproperty
a_dqs_run: assert property (p_dqs_run) else $error("strobe stuck");
c_write: cover property (col_valid_o && col_write_o);
c_pd: cover property ($rose(power_down_o));
c_burst: cover property ($rose(dq_oe_o));
endmodule

// File: verification/ddr3_ctrl_model.sv
/*
 * controller model: free-running link clock pair, command and address pins.
 * assumes the bench flips req_tag_i once per command and waits for ack_o.
 */
`timescale 1ns/10ps
module ddr3_ctrl_model (
    input  wire        req_tag_i,
    input  wire        req_cke_i,
    input  wire        req_cs_n_i,
    input  wire [2:0]  req_cmd_i,
    input  wire [2:0]  req_ba_i,
    input  wire [12:0] req_addr_i,
    output reg         ack_o = 1'b0,
    output reg         ck_o = 1'b0,
    output reg         ck_n_o = 1'b1,
    output reg         cke_o = 1'b1,
    output reg         cs_n_o = 1'b1,
    output reg  [2:0]  cmd_n_o = 3'h7,
    output reg  [2:0]  ba_o = 3'h0,
    output reg  [12:0] addr_o = 13'h0000
);
// system clock of the pair never stops; odd offset keeps it off clk_i edges
initial begin
    #13;
    forever begin
        #40;
        ck_o = ~ck_o;
        ck_n_o = ~ck_o;
    end
end
always @(negedge ck_o) begin
    cke_o <= req_cke_i;
    if (req_tag_i !== ack_o) begin
        {cs_n_o, cmd_n_o, ba_o, addr_o} <= {req_cs_n_i, req_cmd_i, req_ba_i, req_addr_i};
        ack_o <= req_tag_i;
    end else begin
        {cs_n_o, cmd_n_o, ba_o, addr_o} <= {1'b1, ~cmd_n_o, ~ba_o, ~addr_o};
    end
end
endmodule

// File: verification/ddr3_cmd_front_tb.sv
/*
 * self-checking bench for ddr3_cmd_front, stimulus through the controller model.
 * assumes ddr3_cmd_defs.vh on the include path.
 */
`timescale 1ns/10ps
`include "ddr3_cmd_defs.vh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); end end
module ddr3_cmd_front_tb;
reg         clk_i = 0, sys_rst_i = 1, cke = 1, cs_n = 1, tag = 0;
reg  [2:0]  cmd = 3'h7, ba = 3'h0;
reg  [12:0] addr = 13'h0000;
reg  [15:0] rnd = 16'hef76;
reg  [7:0]  exp_open = 8'h00;
reg  [14:0] exp_q[$], got, x;
integer     fail_count = 0, n_tests = 0, cycles = 0, i, lat_start = 0, beats = 0;
reg         prev = 1'b0;
localparam  LINK_CLKS = 8;
wire        ack, ck, ck_n, cke_p, cs_n_p, pd, cv, cw, ap, ilv, dq_oe, dqs, dqs_oe, merr;
wire [2:0]  cmd_p, ba_p, cb;
wire [12:0] addr_p, row;
wire [7:0]  bopen;
wire [9:0]  col;
wire [15:0] dq;
wire [3:0]  blen;
wire [1:0]  alat;
always #5 clk_i = ~clk_i;
ddr3_ctrl_model ddr3_ctrl_model_i (.req_tag_i(tag), .req_cke_i(cke), .req_cs_n_i(cs_n),
    .req_cmd_i(cmd), .req_ba_i(ba), .req_addr_i(addr), .ack_o(ack), .ck_o(ck), .ck_n_o(ck_n),
    .cke_o(cke_p), .cs_n_o(cs_n_p), .cmd_n_o(cmd_p), .ba_o(ba_p), .addr_o(addr_p));
ddr3_cmd_front ddr3_cmd_front_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ck_i(ck),
    .ck_n_i(ck_n), .cke_i(cke_p), .cs_n_i(cs_n_p), .ras_n_i(cmd_p[2]), .cas_n_i(cmd_p[1]),
    .we_n_i(cmd_p[0]), .ba_i(ba_p), .addr_i(addr_p), .bank_open_o(bopen), .power_down_o(pd),
    .act_row_o(row), .col_o(col), .col_bank_o(cb), .col_valid_o(cv), .col_write_o(cw),
    .auto_pre_o(ap), .burst_len_o(blen), .burst_ilv_o(ilv), .add_lat_o(alat), .dq_o(dq),
    .dq_oe_o(dq_oe), .dqs_o(dqs), .dqs_oe_o(dqs_oe), .mode_err_o(merr));
function automatic [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
endfunction
// one command per two link cycles; settle time covers sync plus decode
task automatic issue(input [2:0] c, input [2:0] b, input [12:0] a, input s, input k);
    @(posedge clk_i);
    {cmd, ba, addr, cs_n, cke, tag} <= {c, b, a, s, k, ~tag};
    @(posedge clk_i);
    while (ack !== tag) @(posedge clk_i);
    repeat (12) @(posedge clk_i);
endtask
task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
// ----------------------------------------
// monitor: oldest expected access per strobe
// ----------------------------------------
always @(posedge clk_i) begin
    cycles = cycles + 1;
    // ceiling: about 27 times the run of about 40 commands of 16 cycles plus one read latency
    if (cycles == 20000) begin
        fail_count++;
        conclude;
    end else if (cv === 1'b1) begin
        lat_start = cycles;
        got = exp_q.size() ? exp_q.pop_front() : 15'h7fff;
        `CHK("col_access", got, {ap, cw, cb, col})
    end
end
initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    `CHK("burst_len", 4'h8, blen)
    for (i = 0; i < 8; i++) begin
        rnd = lfsr(rnd);
        issue(`CMD_ACT, i[2:0], rnd[12:0], 1'b0, 1'b1);
        exp_open[i] = 1'b1;
        `CHK("act_row", rnd[12:0], row)
        `CHK("bank_open", exp_open, bopen)
    end
    $display("test activate done");
    issue(`CMD_PRE, 3'h0, 13'h0400, 1'b1, 1'b1);
    `CHK("deselect", exp_open, bopen)
    issue(`CMD_NOP, 3'h0, 13'h0000, 1'b0, 1'b0);
    `CHK("pd_busy", 1'b0, pd)
    // a read with the clock suspended must leave no strobe
    issue(`CMD_RD, 3'h1, 13'h0000, 1'b0, 1'b0);
    issue(`CMD_NOP, 3'h0, 13'h0000, 1'b0, 1'b1);
    $display("test select done");
    for (i = 0; i < 8; i++) begin
        rnd = lfsr(rnd);
        x = {rnd[10], (rnd[0] && i < 7), i[2:0], rnd[9:0]};
        exp_q.push_back(x);
        if (rnd[10]) exp_open[i] = 1'b0;
        issue(x[13] ? `CMD_WR : `CMD_RD, i[2:0], rnd[12:0], 1'b0, 1'b1);
        `CHK("auto_pre", exp_open, bopen)
    end
    for (i = 0; i < 600 && dq_oe !== 1'b1; i++) @(posedge clk_i);
    `CHK("read_burst", 1'b1, dq_oe)
    $display("test access done");
    issue(`CMD_PRE, 3'h0, 13'h0000, 1'b0, 1'b1);
    exp_open[0] = 1'b0;
    `CHK("pre_one", exp_open, bopen)
    issue(`CMD_PRE, 3'h5, 13'h0400, 1'b0, 1'b1);
    `CHK("pre_all", 8'h00, bopen)
    issue(`CMD_REF, 3'h0, 13'h0000, 1'b0, 1'b1);
    `CHK("refresh", 8'h00, bopen)
    issue(`CMD_NOP, 3'h0, 13'h0000, 1'b0, 1'b0);
    `CHK("pd_idle", 1'b1, pd)
    issue(`CMD_ACT, 3'h2, 13'h0055, 1'b0, 1'b0);
    `CHK("pd_frozen", 8'h00, bopen)
    issue(`CMD_NOP, 3'h0, 13'h0000, 1'b0, 1'b1);
    $display("test power_down done");
    for (i = 0; i < 4; i++) begin
        issue(`CMD_MRS, `MR0_SEL, {9'h000, i[0], 1'b0, i[1], 1'b0}, 1'b0, 1'b1);
        `CHK("burst_len", i[1] ? 4'h4 : 4'h8, blen)
        `CHK("burst_ilv", i[0], ilv)
    end
    // illegal burst field flagged, then chop chosen per access by address bit twelve
    issue(`CMD_MRS, `MR0_SEL, 13'h0003, 1'b0, 1'b1);
    `CHK("mode_err", 1'b1, merr)
    issue(`CMD_MRS, `MR0_SEL, 13'h0001, 1'b0, 1'b1);
    `CHK("mode_err", 1'b0, merr)
    issue(`CMD_ACT, 3'h3, 13'h0123, 1'b0, 1'b1);
    for (i = 0; i < 2; i++) begin
        exp_q.push_back({2'h0, 3'h3, 10'h008});
        issue(`CMD_RD, 3'h3, {i[0], 12'h008}, 1'b0, 1'b1);
        `CHK("burst_chop", i[0] ? 4'h8 : 4'h4, blen)
    end
    for (i = 0; i < 300 && dq_oe !== 1'b1; i++) @(posedge clk_i);
    beats = cycles - lat_start - LINK_CLKS * `CAS_LAT;
    `CHK("read_lat", 1'b1, beats >= 0 && beats <= LINK_CLKS)
    beats = 0;
    prev = 1'b0;
    while (dq_oe === 1'b1) begin
        if (dqs !== prev) begin
            `CHK("dq_beat", 16'h0008 + beats, dq)
            beats++;
        end
        prev = dqs;
        @(posedge clk_i);
    end
    `CHK("beats", 8, beats)
    $display("test chop done");
    for (i = 0; i < 4; i++) begin
        issue(`CMD_MRS, `MR1_SEL, {8'h00, i[1:0], 3'h0}, 1'b0, 1'b1);
        `CHK("add_lat", (i == 3) ? 2'h2 : i[1:0], alat)
        `CHK("mode_err", (i == 3), merr)
    end
    `CHK("queue_left", 0, exp_q.size())
    $display("test mode done");
    conclude;
end
endmodule
bind ddr3_cmd_front ddr3_cmd_front_asserts #(.NBANK(NBANK)) ddr3_cmd_front_asserts_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
    .bank_open_o(bank_open_o), .power_down_o(power_down_o), .col_o(col_o),
    .col_valid_o(col_valid_o), .col_write_o(col_write_o), .burst_len_o(burst_len_o),
    .add_lat_o(add_lat_o), .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o));
